// [src/table_jump_extend_trap_test_exec.sv]
// Overview of operation
// RL1: Table jump address is the address after the instruction plus the index register times two.
// RL2: Table jump loads that halfword, sign-extends it, doubles it, adds PC+2 and branches there.
// RL3: Byte sign extension replaces the register with its bits 7:0 extended to 32 bits.
// RL4: Halfword sign extension replaces the register with its bits 15:0 extended to 32 bits.
// RL5: Trap saves PC+4 as return address and copies the status word to the saved status.
// RL6: Trap writes the interrupt code of the vector into the cause code field.
// RL7: Trap sets exception-pending and interrupt-disable and leaves other flags alone.
// RL8: Trap branches to 40H for vectors 00H-0FH and to 50H for vectors 10H-1FH.
// RL9: Test ANDs the two source registers, keeps no result and only updates flags.
// RL10: Test sets sign from the result's top bit and zero when the result is zero.
// RL11: Test clears overflow, keeps carry and saturation and leaves the sources intact.
// RL12: Table jump and both sign extensions leave all arithmetic flags unchanged.
// RL13: Trap is a 32-bit encoding whose vector is a five-bit field.
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.svh"

module table_jump_extend_trap_test_exec #(
  parameter int RF_AW = 5
) (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  // Avalon-MM slave
  input  wire logic [3:0]               avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest,
  // Halfword memory load port
  output exec_pkg::load_req_t           mem_load,
  input  wire logic                     mem_ack,
  input  wire logic [15:0]              mem_rdata,
  // Interrupt
  output logic                          irq
);

  // ****************************************
  // Bus slave
  // ****************************************
  logic                    ack_q;
  logic                    acc;
  logic                    host_wr;
  logic                    idle;
  exec_pkg::exec_state_t   st_q;
  logic [31:0]             instr_q;
  logic [31:0]             pc_q;
  exec_pkg::status_word_t  status_q;
  logic [31:0]             ret_pc_q;
  logic [31:0]             saved_st_q;
  logic [31:0]             cause_q;
  logic [RF_AW-1:0]        rf_idx_q;
  logic [`IRQ_W-1:0]       irq_sts_q;
  logic [`IRQ_W-1:0]       irq_mask_q;
  logic [31:0]             opa;
  logic [31:0]             opb;

  // Every access waits one cycle so read data can come from a flop
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign acc             = (avs_read | avs_write) & ack_q;
  assign host_wr         = acc & avs_write;
  assign idle            = (st_q == exec_pkg::ST_IDLE);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack_q) begin
      case (avs_address)
        `REG_INSTR:    avs_readdata <= instr_q;
        `REG_PC:       avs_readdata <= pc_q;
        `REG_STATUS:   avs_readdata <= status_q;
        `REG_RET_PC:   avs_readdata <= ret_pc_q;
        `REG_SAVED_ST: avs_readdata <= saved_st_q;
        `REG_CAUSE:    avs_readdata <= cause_q;
        `REG_RF_INDEX: avs_readdata <= {{(32-RF_AW){1'b0}}, rf_idx_q};
        `REG_RF_DATA:  avs_readdata <= opa;
        `REG_IRQ_STS:  avs_readdata <= {{(32-`IRQ_W){1'b0}}, irq_sts_q};
        `REG_IRQ_MASK: avs_readdata <= {{(32-`IRQ_W){1'b0}}, irq_mask_q};
        `REG_ENGINE:   avs_readdata <= {31'h00000000, ~idle};
        default:       avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // Instruction is only accepted while idle; register index and IRQ mask are accepted at any time
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      instr_q    <= 32'h00000000;
      rf_idx_q   <= '0;
      irq_mask_q <= '0;
    end else if (host_wr) begin
      if (avs_address == `REG_INSTR && idle) begin
        instr_q <= avs_writedata;
      end
      if (avs_address == `REG_RF_INDEX) begin
        rf_idx_q <= avs_writedata[RF_AW-1:0];
      end
      if (avs_address == `REG_IRQ_MASK) begin
        irq_mask_q <= avs_writedata[`IRQ_W-1:0];
      end
    end
  end

  // ****************************************
  // Decode
  // ****************************************
  logic [4:0]  f_r1;
  logic [4:0]  f_r2;
  logic [4:0]  vec;
  logic        dec_switch;
  logic        dec_byte_ext;
  logic        dec_half_ext;
  logic        dec_and_test;
  logic        dec_trap;
  logic        exec;
  logic        go;
  logic [31:0] ext_val;
  logic [31:0] and_res;
  logic [31:0] next_pc;
  logic [31:0] tbl_target;

  assign f_r1       = instr_q[4:0];
  assign f_r2       = instr_q[15:11];
  assign vec        = instr_q[4:0];                                  // [RL13]
  assign dec_switch = (instr_q[15:5] == `OP_SWITCH);
  assign dec_byte_ext = (instr_q[15:5] == `OP_BYTE_EXT);
  assign dec_half_ext = (instr_q[15:5] == `OP_HALF_EXT);
  assign dec_and_test = (instr_q[10:5] == `OP_AND_TEST);
  assign dec_trap   = (instr_q[15:5] == `OP_TRAP_LO)
                    && (instr_q[31:16] == `OP_TRAP_HI);              // [RL13]
  assign exec       = (st_q == exec_pkg::ST_EXEC);
  assign go         = host_wr && avs_address == `REG_CTRL
                    && avs_writedata[`CTRL_GO_BIT] && idle;
  assign next_pc    = pc_q + `STEP_HALF;
  assign ext_val    = dec_byte_ext ? {{24{opa[7]}}, opa[7:0]}        // [RL3]
                                   : {{16{opa[15]}}, opa[15:0]};     // [RL4]
  assign and_res    = opa & opb;                                     // [RL9]
  assign tbl_target = next_pc + ({{16{mem_rdata[15]}}, mem_rdata} << 1); // [RL2]

  // ****************************************
  // Register file
  // ****************************************
  logic             rf_wr;
  logic [RF_AW-1:0] rf_waddr;
  logic [31:0]      rf_wdata;
  logic             exec_wr;

  // Only the extend ops write back; test keeps both sources intact
  assign exec_wr  = exec && (dec_byte_ext || dec_half_ext);          // [RL9] [RL11]
  assign rf_wr    = exec_wr || (host_wr && avs_address == `REG_RF_DATA && idle);
  assign rf_waddr = exec_wr ? f_r1 : rf_idx_q;
  assign rf_wdata = exec_wr ? ext_val : avs_writedata;               // [RL3] [RL4]

  general_register_file #(
    .AW (RF_AW),
    .DW (32)
  ) u_rf (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .wr_en     (rf_wr),
    .wr_addr   (rf_waddr),
    .wr_data   (rf_wdata),
    .rd_addr_a (idle ? rf_idx_q : f_r1),
    .rd_data_a (opa),
    .rd_addr_b (f_r2),
    .rd_data_b (opb)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= exec_pkg::ST_IDLE;
    end else begin
      case (st_q)
        exec_pkg::ST_IDLE: if (go) st_q <= exec_pkg::ST_READ;
        exec_pkg::ST_READ: st_q <= exec_pkg::ST_EXEC;
        exec_pkg::ST_EXEC: st_q <= dec_switch ? exec_pkg::ST_LOAD : exec_pkg::ST_IDLE;
        exec_pkg::ST_LOAD: if (mem_ack) st_q <= exec_pkg::ST_IDLE;
        default:           st_q <= exec_pkg::ST_IDLE;
      endcase
    end
  end

  // Request is held until the memory acknowledges
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_load <= '0;
    end else if (exec && dec_switch) begin
      mem_load.req  <= 1'b1;
      mem_load.addr <= next_pc + (opa << 1);                         // [RL1]
    end else if (mem_ack) begin
      mem_load.req <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_q <= `RST_PC;
    end else if (st_q == exec_pkg::ST_LOAD && mem_ack) begin
      pc_q <= tbl_target;                                            // [RL2]
    end else if (exec) begin
      if (dec_trap) begin
        pc_q <= vec[4] ? `HANDLER_HI : `HANDLER_LO;                  // [RL8]
      end else if (dec_byte_ext || dec_half_ext || dec_and_test) begin
        pc_q <= next_pc;
      end
    end else if (host_wr && avs_address == `REG_PC && idle) begin
      pc_q <= avs_writedata;
    end
  end

  // Carry and saturation are only changed here by a host status write
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= `RST_STATUS;
    end else if (exec && dec_trap) begin
      status_q.exception_pending_flag <= 1'b1;                       // [RL7]
      status_q.interrupt_disable_flag <= 1'b1;                       // [RL7]
    end else if (exec && dec_and_test) begin
      status_q.sign_flag     <= and_res[31];                         // [RL10]
      status_q.zero_flag     <= (and_res == 32'h00000000);           // [RL10]
      status_q.overflow_flag <= 1'b0;                                // [RL11]
    end else if (host_wr && avs_address == `REG_STATUS && idle) begin
      status_q <= avs_writedata;
    end
  end

  // Upper cause half belongs to other exception sources and is kept
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ret_pc_q   <= 32'h00000000;
      saved_st_q <= 32'h00000000;
      cause_q    <= 32'h00000000;
    end else if (exec && dec_trap) begin
      ret_pc_q      <= pc_q + `STEP_WORD;                            // [RL5]
      saved_st_q    <= status_q;                                     // [RL5]
      cause_q[15:0] <= `CAUSE_BASE + {11'h000, vec};                 // [RL6]
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic [`IRQ_W-1:0] ev;
  logic [`IRQ_W-1:0] clr;

  assign ev[`IRQ_DONE_BIT] = (exec && !dec_switch)
                           || (st_q == exec_pkg::ST_LOAD && mem_ack);
  assign ev[`IRQ_TRAP_BIT] = exec && dec_trap;
  assign ev[`IRQ_ILL_BIT]  = exec && !(dec_switch || dec_byte_ext || dec_half_ext
                                       || dec_and_test || dec_trap);
  // Only bits that were reported are cleared; a new event wins
  assign clr = (acc && avs_read && avs_address == `REG_IRQ_STS)
             ? avs_readdata[`IRQ_W-1:0] : '0;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_sts_q <= '0;
    end else begin
      irq_sts_q <= ev | (irq_sts_q & ~clr);
    end
  end

  assign irq = |(irq_sts_q & irq_mask_q);

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  chk_switch_addr: assert property (exec && dec_switch |=> mem_load.req // [RL1]
      && mem_load.addr == $past(pc_q) + 32'h2 + ($past(opa) << 1))
    else $error("table entry address wrong");
  chk_switch_target: assert property (st_q == exec_pkg::ST_LOAD && mem_ack // [RL2]
      |=> pc_q == $past(pc_q) + 32'h2
          + ({{16{$past(mem_rdata[15])}}, $past(mem_rdata)} << 1))
    else $error("table jump target wrong");
  chk_byte_ext_write: assert property (exec && dec_byte_ext // [RL3]
      |-> rf_wr && rf_waddr == f_r1 && rf_wdata == {{24{opa[7]}}, opa[7:0]})
    else $error("byte extend write wrong");
  chk_half_ext_write: assert property (exec && dec_half_ext // [RL4]
      |-> rf_wr && rf_waddr == f_r1 && rf_wdata == {{16{opa[15]}}, opa[15:0]})
    else $error("halfword extend write wrong");
  chk_trap_save: assert property (exec && dec_trap // [RL5]
      |=> ret_pc_q == $past(pc_q) + 32'h4 && saved_st_q == $past(status_q))
    else $error("trap context not saved");
  chk_trap_cause: assert property (exec && dec_trap // [RL6]
      |=> cause_q[15:0] == 16'h0040 + {11'h000, $past(vec)})
    else $error("trap cause code wrong");
  chk_trap_flags: assert property (exec && dec_trap // [RL7]
      |=> status_q.exception_pending_flag && status_q.interrupt_disable_flag
          && status_q[4:0] == $past(status_q[4:0]))
    else $error("trap status update wrong");
  chk_trap_vector: assert property (exec && dec_trap // [RL8]
      |=> pc_q == ($past(vec[4]) ? 32'h50 : 32'h40))
    else $error("trap handler address wrong");
  chk_test_nowrite: assert property (exec && dec_and_test |-> !rf_wr) // [RL9]
    else $error("test wrote a register");
  chk_test_flags: assert property (exec && dec_and_test // [RL10]
      |=> status_q.sign_flag == $past(and_res[31])
          && status_q.zero_flag == ($past(and_res) == 32'h0))
    else $error("test sign or zero wrong");
  chk_test_keep: assert property (exec && dec_and_test |=> !status_q.overflow_flag // [RL11]
      && status_q.carry_flag == $past(status_q.carry_flag)
      && status_q.saturation_flag == $past(status_q.saturation_flag))
    else $error("test overflow or kept flags wrong");
  chk_ext_flags: assert property (exec && (dec_switch || dec_byte_ext || dec_half_ext) // [RL12]
      |=> status_q == $past(status_q) [*2])
    else $error("flags changed by jump or extend");

  cov_trap_high: cover property (exec && dec_trap && vec[4]);
  cov_switch_done: cover property (st_q == exec_pkg::ST_LOAD && mem_ack);
  cov_test_zero: cover property (exec && dec_and_test && and_res == 32'h0);
  cov_irq: cover property (irq);

endmodule // table_jump_extend_trap_test_exec

`default_nettype wire

// [src/exec_defs.svh]
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

// ****************************************
// Register word indices on the bus
// ****************************************
`define REG_INSTR     4'h0
`define REG_CTRL      4'h1
`define REG_PC        4'h2
`define REG_STATUS    4'h3
`define REG_RET_PC    4'h4
`define REG_SAVED_ST  4'h5
`define REG_CAUSE     4'h6
`define REG_RF_INDEX  4'h7
`define REG_RF_DATA   4'h8
`define REG_IRQ_STS   4'h9
`define REG_IRQ_MASK  4'hA
`define REG_ENGINE    4'hB

// ****************************************
// Fields, reset values and constants
// ****************************************
`define CTRL_GO_BIT   0
`define IRQ_DONE_BIT  0
`define IRQ_TRAP_BIT  1
`define IRQ_ILL_BIT   2
`define IRQ_W         3
`define RST_PC        32'h00000000
`define RST_STATUS    32'h00000020
`define OP_SWITCH     11'h002
`define OP_BYTE_EXT   11'h005
`define OP_HALF_EXT   11'h007
`define OP_AND_TEST   6'h0B
`define OP_TRAP_LO    11'h03F
`define OP_TRAP_HI    16'h0100
`define HANDLER_LO    32'h00000040
`define HANDLER_HI    32'h00000050
`define CAUSE_BASE    16'h0040
`define STEP_HALF     32'h00000002
`define STEP_WORD     32'h00000004

`endif

// [src/exec_pkg.sv]
package exec_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_EXEC,
    ST_LOAD
  } exec_state_t;

  typedef struct packed {
    logic [24:0] rsvd;
    logic        exception_pending_flag;
    logic        interrupt_disable_flag;
    logic        saturation_flag;
    logic        carry_flag;
    logic        overflow_flag;
    logic        sign_flag;
    logic        zero_flag;
  } status_word_t;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
  } load_req_t;

endpackage

// [src/general_register_file.sv]
`timescale 1ns/1ps
`default_nettype none

module general_register_file #(
  parameter int AW = 5,
  parameter int DW = 32
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          sys_rst,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read ports, one cycle latency
  input  wire logic [AW-1:0] rd_addr_a,
  output logic      [DW-1:0] rd_data_a,
  input  wire logic [AW-1:0] rd_addr_b,
  output logic      [DW-1:0] rd_data_b
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_a <= '0;
      rd_data_b <= '0;
    end else begin
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
    end
  end

endmodule // general_register_file

`default_nettype wire

// [dv/mem_load_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Halfword memory answering the load port
// ****************************************
module mem_load_model (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  // Load port
  input  wire exec_pkg::load_req_t mem_load,
  output logic                     mem_ack,
  output logic [15:0]              mem_rdata,
  // Bench control and observation
  input  wire logic [15:0]         entry,
  input  wire logic [3:0]          delay,
  output logic [31:0]              seen_addr
);
  logic [3:0] wait_q;

  // Data toggles when not acknowledged, so a stale capture never matches
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_q    <= 4'h0;
      mem_ack   <= 1'b0;
      mem_rdata <= 16'h0000;
      seen_addr <= 32'h00000000;
    end else if (mem_load.req && !mem_ack && wait_q >= delay) begin
      mem_ack   <= 1'b1;
      mem_rdata <= entry;
      seen_addr <= mem_load.addr;
      wait_q    <= 4'h0;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_q    <= (mem_load.req && !mem_ack) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule // mem_load_model

`default_nettype wire

// [dv/tb_table_jump_extend_trap_test_exec.sv]
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.svh"

module tb_table_jump_extend_trap_test_exec;
  logic                sys_clk = 1'b0;
  logic                sys_rst = 1'b1;
  logic [3:0]          avs_address = 4'h0;
  logic                avs_read = 1'b0;
  logic                avs_write = 1'b0;
  logic [31:0]         avs_writedata = 32'h00000000;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  exec_pkg::load_req_t mem_load;
  logic                mem_ack;
  logic [15:0]         mem_rdata;
  logic                irq;
  logic [15:0]         entry = 16'h0000;
  logic [3:0]          delay = 4'h0;
  logic [31:0]         seen_addr;
  int                  miscompares = 0;
  int                  n_compared = 0;
  int                  cycles = 0;

  always #20 sys_clk = ~sys_clk;

  table_jump_extend_trap_test_exec table_jump_extend_trap_test_exec_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mem_load(mem_load), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .irq(irq));

  mem_load_model mem_load_model_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .mem_load(mem_load), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .entry(entry), .delay(delay), .seen_addr(seen_addr));

  // ****************************************
  // Reporting
  // ****************************************
  task results();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  // ****************************************
  // Avalon master and helpers
  // ****************************************
  // One idle edge before each request keeps strobes from being assigned twice in a step
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task set_rf(input logic [4:0] r, input logic [31:0] d);
    wr(`REG_RF_INDEX, {27'h0000000, r});
    wr(`REG_RF_DATA, d);
  endtask

  task get_rf(input logic [4:0] r, output logic [31:0] d);
    wr(`REG_RF_INDEX, {27'h0000000, r});
    rd(`REG_RF_DATA, d);
  endtask

  // Poke writes PC while busy; that write must be refused
  task run(input logic [31:0] instr, input logic poke);
    logic [31:0] v;
    wr(`REG_INSTR, instr);
    wr(`REG_CTRL, 32'h00000001);
    if (poke) wr(`REG_PC, 32'hDEAD0000);
    for (int i = 0; i < 40; i++) begin
      rd(`REG_ENGINE, v);
      if (v[0] === 1'b0) break;
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset();
    logic [31:0] v;
    rd(`REG_PC, v);
    check(v, 32'h00000000);
    rd(`REG_STATUS, v);
    check(v, 32'h00000020);
    check({31'h0, irq}, 32'h00000000);
    wr(4'hC, 32'h00000055);
    rd(4'hC, v);
    check(v, 32'h00000000);
    wr(`REG_RET_PC, 32'h12345678);
    rd(`REG_RET_PC, v);
    check(v, 32'h00000000);
  endtask

  task t_extend();
    logic [31:0] src [4] = '{32'h00000080, 32'h1234567F, 32'h00008000, 32'hFFFF7FFF};
    logic [31:0] exp [4] = '{32'hFFFFFF80, 32'h0000007F, 32'hFFFF8000, 32'h00007FFF};
    logic [31:0] v;
    for (int i = 0; i < 4; i++) begin
      set_rf(5'(5 + i), src[i]);
      wr(`REG_STATUS, 32'h0000001F);
      run({16'h0000, (i < 2) ? `OP_BYTE_EXT : `OP_HALF_EXT, 5'(5 + i)}, 1'b0);
      get_rf(5'(5 + i), v);
      check(v, exp[i]);
      rd(`REG_STATUS, v);
      check(v, 32'h0000001F);
    end
  endtask

  task t_test();
    logic [31:0] a [3] = '{32'hF0F0F0F0, 32'h80000001, 32'h00000007};
    logic [31:0] b [3] = '{32'h0F0F0F0F, 32'h80000000, 32'h00000003};
    logic [31:0] si [3] = '{32'h0000001C, 32'h00000007, 32'h0000001F};
    logic [31:0] so [3] = '{32'h00000019, 32'h00000002, 32'h00000018};
    logic [31:0] v;
    for (int i = 0; i < 3; i++) begin
      set_rf(5'd2, a[i]);
      set_rf(5'd9, b[i]);
      wr(`REG_STATUS, si[i]);
      run({16'h0000, 5'd9, `OP_AND_TEST, 5'd2}, 1'b0);
      rd(`REG_STATUS, v);
      check(v, so[i]);
      get_rf(5'd2, v);
      check(v, a[i]);
      get_rf(5'd9, v);
      check(v, b[i]);
    end
  endtask

  task t_trap();
    logic [4:0]  vec [4] = '{5'h00, 5'h0F, 5'h10, 5'h1F};
    logic [31:0] v;
    for (int i = 0; i < 4; i++) begin
      wr(`REG_STATUS, 32'h0000001B);
      wr(`REG_PC, 32'h00000300);
      run({`OP_TRAP_HI, `OP_TRAP_LO, vec[i]}, 1'b0);
      rd(`REG_RET_PC, v);
      check(v, 32'h00000304);
      rd(`REG_SAVED_ST, v);
      check(v, 32'h0000001B);
      rd(`REG_CAUSE, v);
      check({16'h0000, v[15:0]}, 32'h00000040 + {27'h0, vec[i]});
      rd(`REG_STATUS, v);
      check(v, 32'h0000007B);
      rd(`REG_PC, v);
      check(v, vec[i][4] ? 32'h00000050 : 32'h00000040);
      rd(`REG_IRQ_STS, v);
      check(v & 32'h00000002, 32'h00000002);
    end
  endtask

  // Second case: index top bit shifts out, positive entry, slow memory, busy write
  task t_switch();
    logic [31:0] pc [2] = '{32'h00000200, 32'h00001000};
    logic [31:0] ix [2] = '{32'h00000005, 32'h80000010};
    logic [15:0] en [2] = '{16'hFFFC, 16'h7FFF};
    logic [31:0] ad [2] = '{32'h0000020C, 32'h00001022};
    logic [31:0] tg [2] = '{32'h000001FA, 32'h00011000};
    logic [31:0] v;
    for (int i = 0; i < 2; i++) begin
      set_rf(5'd3, ix[i]);
      wr(`REG_STATUS, 32'h0000001F);
      wr(`REG_PC, pc[i]);
      entry <= en[i];
      delay <= (i == 0) ? 4'h0 : 4'h9;
      run({16'h0000, `OP_SWITCH, 5'd3}, i == 1);
      check(seen_addr, ad[i]);
      rd(`REG_PC, v);
      check(v, tg[i]);
      rd(`REG_STATUS, v);
      check(v, 32'h0000001F);
    end
  endtask

  task t_irq();
    logic [31:0] v;
    rd(`REG_IRQ_STS, v);
    wr(`REG_IRQ_MASK, 32'h00000000);
    set_rf(5'd5, 32'h00000001);
    run({16'h0000, `OP_BYTE_EXT, 5'd5}, 1'b0);
    check({31'h0, irq}, 32'h00000000);
    wr(`REG_IRQ_MASK, 32'h00000007);
    @(posedge sys_clk);
    check({31'h0, irq}, 32'h00000001);
    rd(`REG_IRQ_STS, v);
    check(v & 32'h00000001, 32'h00000001);
    @(posedge sys_clk);
    check({31'h0, irq}, 32'h00000000);
    wr(`REG_PC, 32'h00000400);
    run(32'hFFFFFFFF, 1'b0);
    rd(`REG_IRQ_STS, v);
    check(v & 32'h00000004, 32'h00000004);
    rd(`REG_PC, v);
    check(v, 32'h00000400);
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_extend();
    t_test();
    t_trap();
    t_switch();
    t_irq();
    results();
  end
endmodule // tb_table_jump_extend_trap_test_exec

`default_nettype wire
